// *** src/fcl_blinker.sv ***
`timescale 1ns/1ps
`default_nettype none

module fcl_blinker
    import fcl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [31:0] half_cyc_in,
    output logic phase_out
);

    logic [31:0] cnt_ff;
    logic phase_ff;

    // a stopped blinker restarts in the lit half, so a new pattern shows at once
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            cnt_ff <= CNT_RST;
        end
        else if (cnt_ff >= half_cyc_in - CNT_STEP)
        begin
            cnt_ff <= CNT_RST;
        end
        else
        begin
            cnt_ff <= cnt_ff + CNT_STEP;
        end
    end

    // equal lit and dark halves give the 50 percent duty
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            phase_ff <= PHASE_RST;
        end
        else if (cnt_ff >= half_cyc_in - CNT_STEP)
        begin
            phase_ff <= ~phase_ff;
        end
    end

    assign phase_out = phase_ff;

    a_toggle_cause: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ($past(run_in) && run_in && (phase_ff != $past(phase_ff)))
            |-> ($past(cnt_ff) == $past(half_cyc_in) - CNT_STEP))
        else $error("blink phase changed before its half period ran out");

    a_count_bound: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (run_in && $stable(half_cyc_in)) |=> (cnt_ff < half_cyc_in))
        else $error("blink counter passed its half period");

endmodule

`default_nettype wire

// *** src/fcl_lamps.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// - link lamp steady on during setup
// - link lamp blinks 0.5s on, 0.5s off
// - link lamp off when disconnected
// - online lamp lit while online
// - online lamp dark when not online
// - fault lamp steady while offline
// - configuration error blinks fault lamp 1 Hz
// - parameter error blinks fault lamp 2 Hz
// - interface chip error blinks 4 Hz
// - fault lamp dark when diagnosis disabled
// - request-to-send output shows transmit direction
module fcl_lamps
    import fcl_pkg::*;
#(
    parameter int unsigned LINK_HALF = LINK_HALF_CYC,
    parameter int unsigned CFG_HALF = CFG_HALF_CYC,
    parameter int unsigned PRM_HALF = PRM_HALF_CYC,
    parameter int unsigned ASIC_HALF = ASIC_HALF_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_setup_in,
    input wire logic link_connected_in,
    input wire logic card_online_in,
    input wire logic card_offline_in,
    input wire logic cfg_err_in,
    input wire logic prm_err_in,
    input wire logic asic_err_in,
    input wire logic diag_enable_in,
    input wire logic board_power_in,
    input wire logic tx_active_in,
    output logic link_status_lamp_out,
    output logic online_lamp_out,
    output logic offline_fault_lamp_out,
    output logic power_lamp_out,
    output logic rts_out
);

    fcl_link_t link_st_ff;
    fcl_link_t nxt_link_st;
    fcl_flt_t flt_st_ff;
    fcl_flt_t nxt_flt_st;
    logic link_phase;
    logic flt_phase;
    logic flt_run;
    logic [31:0] flt_half;
    logic link_status_lamp_ff;
    logic online_lamp_ff;
    logic offline_fault_lamp_ff;
    logic power_lamp_ff;
    logic rts_ff;

    // worst fault wins; diagnosis off silences all of them
    function automatic fcl_flt_t flt_decode(input logic diag, input logic asic,
                                           input logic prm, input logic cfg,
                                           input logic offline);
        fcl_flt_t res;
        res = FLT_DARK;
        if (!diag)
            res = FLT_DARK;
        else if (asic)
            res = FLT_ASIC;
        else if (prm)
            res = FLT_PRM;
        else if (cfg)
            res = FLT_CFG;
        else if (offline)
            res = FLT_STEADY;
        return res;
    endfunction

    // connected outranks setup if both flags are seen together
    always_comb
    begin
        if (link_connected_in)
            nxt_link_st = LINK_UP;
        else if (link_setup_in)
            nxt_link_st = LINK_SETUP;
        else
            nxt_link_st = LINK_DOWN;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            link_st_ff <= LINK_DOWN;
        else
            link_st_ff <= nxt_link_st;
    end

    assign nxt_flt_st = flt_decode(diag_enable_in, asic_err_in, prm_err_in,
                                   cfg_err_in, card_offline_in);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            flt_st_ff <= FLT_DARK;
        else
            flt_st_ff <= nxt_flt_st;
    end

    always_comb
    begin
        case (flt_st_ff)
            FLT_ASIC: flt_half = 32'(ASIC_HALF);
            FLT_PRM: flt_half = 32'(PRM_HALF);
            FLT_CFG: flt_half = 32'(CFG_HALF);
            default: flt_half = 32'(CFG_HALF);
        endcase
    end

    // a pattern change stops the blinker for a cycle so the new rate starts clean
    assign flt_run = (flt_st_ff == nxt_flt_st) &&
                     ((flt_st_ff == FLT_ASIC) || (flt_st_ff == FLT_PRM) ||
                      (flt_st_ff == FLT_CFG));

    fcl_blinker u_link_blink (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(link_st_ff == LINK_UP),
        .half_cyc_in(32'(LINK_HALF)),
        .phase_out(link_phase)
    );

    fcl_blinker u_flt_blink (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(flt_run),
        .half_cyc_in(flt_half),
        .phase_out(flt_phase)
    );

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            link_status_lamp_ff <= LAMP_RST;
        else
        begin
            case (link_st_ff)
                LINK_SETUP: link_status_lamp_ff <= 1'h1;
                LINK_UP: link_status_lamp_ff <= link_phase;
                default: link_status_lamp_ff <= 1'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            online_lamp_ff <= LAMP_RST;
        else
            online_lamp_ff <= card_online_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            offline_fault_lamp_ff <= LAMP_RST;
        else
        begin
            case (flt_st_ff)
                FLT_STEADY: offline_fault_lamp_ff <= 1'h1;
                FLT_CFG, FLT_PRM, FLT_ASIC: offline_fault_lamp_ff <= flt_phase;
                default: offline_fault_lamp_ff <= 1'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            power_lamp_ff <= LAMP_RST;
        else
            power_lamp_ff <= board_power_in;
    end

    // line equipment only needs direction, so one cycle of lag is harmless
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rts_ff <= LAMP_RST;
        else
            rts_ff <= tx_active_in;
    end

    assign link_status_lamp_out = link_status_lamp_ff;
    assign online_lamp_out = online_lamp_ff;
    assign offline_fault_lamp_out = offline_fault_lamp_ff;
    assign power_lamp_out = power_lamp_ff;
    assign rts_out = rts_ff;

    sequence s_setup_held;
        !link_connected_in && link_setup_in ##1 !link_connected_in && link_setup_in;
    endsequence

    sequence s_down_held;
        !link_connected_in && !link_setup_in ##1 !link_connected_in && !link_setup_in;
    endsequence

    sequence s_diag_off_held;
        !diag_enable_in ##1 !diag_enable_in;
    endsequence

    a_link_setup_lit: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_setup_held |=> link_status_lamp_out)
        else $error("link lamp not lit during setup");

    a_link_down_dark: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_down_held |=> !link_status_lamp_out)
        else $error("link lamp lit while disconnected");

    a_link_up_blinks: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (link_st_ff == LINK_UP && $stable(link_st_ff)) |=> (link_status_lamp_out == $past(link_phase)))
        else $error("link lamp does not follow blink phase");

    a_online_follow: assert property (
        @(posedge clk_in) disable iff (rst_in)
        card_online_in |=> online_lamp_out)
        else $error("online lamp dark while online");

    a_online_dark: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !card_online_in |=> !online_lamp_out)
        else $error("online lamp lit while not online");

    a_diag_off_dark: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_diag_off_held |=> !offline_fault_lamp_out)
        else $error("fault lamp lit with diagnosis disabled");

    a_fault_priority: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (diag_enable_in && asic_err_in)
            |=> (flt_st_ff == FLT_ASIC && flt_half == 32'(ASIC_HALF)))
        else $error("chip error not shown at its rate");

    a_fault_rate: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (diag_enable_in && prm_err_in && !asic_err_in)
            |=> (flt_st_ff == FLT_PRM && flt_half == 32'(PRM_HALF)))
        else $error("parameter error not shown at its rate");

    a_cfg_rate: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (diag_enable_in && cfg_err_in && !prm_err_in && !asic_err_in)
            |=> (flt_st_ff == FLT_CFG && flt_half == 32'(CFG_HALF)))
        else $error("configuration error not shown at its rate");

    a_offline_steady: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (flt_st_ff == FLT_STEADY) |=> offline_fault_lamp_out)
        else $error("fault lamp not steady while offline");

    a_power_lamp: assert property (
        @(posedge clk_in) disable iff (rst_in)
        board_power_in |=> power_lamp_out)
        else $error("power lamp dark while powered");

    a_power_dark: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !board_power_in |=> !power_lamp_out)
        else $error("power lamp lit while unpowered");

    a_rts_follow: assert property (
        @(posedge clk_in) disable iff (rst_in)
        tx_active_in |=> rts_out)
        else $error("request to send does not follow transmit");

    a_rts_idle: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !tx_active_in |=> !rts_out)
        else $error("request to send high while receiving");

endmodule

`default_nettype wire

// *** src/fcl_pkg.sv ***
package fcl_pkg;

    // timing base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned HZ_PER_KHZ = 1000;

    // half periods of each blink pattern, in milliseconds
    localparam int unsigned LINK_HALF_MS = 500;
    localparam int unsigned CFG_HALF_MS = 500;
    localparam int unsigned PRM_HALF_MS = 250;
    localparam int unsigned ASIC_HALF_MS = 125;

    // half periods in clock cycles, derived from the rate
    localparam int unsigned LINK_HALF_CYC = CLK_HZ / HZ_PER_KHZ * LINK_HALF_MS;
    localparam int unsigned CFG_HALF_CYC = CLK_HZ / HZ_PER_KHZ * CFG_HALF_MS;
    localparam int unsigned PRM_HALF_CYC = CLK_HZ / HZ_PER_KHZ * PRM_HALF_MS;
    localparam int unsigned ASIC_HALF_CYC = CLK_HZ / HZ_PER_KHZ * ASIC_HALF_MS;

    // reset values
    localparam logic LAMP_RST = 1'h0;
    localparam logic PHASE_RST = 1'h1;
    localparam logic [31:0] CNT_RST = 32'h0;
    localparam logic [31:0] CNT_STEP = 32'h1;

    typedef enum logic [1:0] {
        LINK_DOWN = 2'h0,
        LINK_SETUP = 2'h1,
        LINK_UP = 2'h3
    } fcl_link_t;

    typedef enum logic [2:0] {
        FLT_DARK = 3'h0,
        FLT_STEADY = 3'h1,
        FLT_CFG = 3'h3,
        FLT_PRM = 3'h2,
        FLT_ASIC = 3'h6
    } fcl_flt_t;

endpackage

// *** verif/fcl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// stands in for the control board: link state and card power
module fcl_host_model
    import fcl_pkg::*;
(
    input wire logic clk_in,
    input wire fcl_link_t mode_in,
    input wire logic power_in,
    output logic link_setup_out,
    output logic link_connected_out,
    output logic board_power_out
);
    initial
    begin
        link_setup_out = 1'h0;
        link_connected_out = 1'h0;
        board_power_out = 1'h0;
    end

    // one edge of lag, as a registered board output would have
    // updated on the edge itself, so the bench's delayed stimulus never races it
    always @(posedge clk_in)
    begin
        link_setup_out <= (mode_in == LINK_SETUP);
        link_connected_out <= (mode_in == LINK_UP);
        board_power_out <= power_in;
    end
endmodule

`default_nettype wire

// *** verif/fcl_lamps_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module fcl_lamps_bench
    import fcl_pkg::*;
;
    // short half periods keep the run small; expectations use these
    localparam int unsigned LH = 8;
    localparam int unsigned CH = 8;
    localparam int unsigned PH = 4;
    localparam int unsigned AH = 2;

    logic clk_in = 1'h0;
    logic rst_in;
    fcl_link_t mode;
    logic pwr_req;
    logic setup, conn, pwr;
    logic online, offline, cfg, prm, asic, diag, tx;
    logic link_l, onl_l, flt_l, pwr_l, rts;
    int err_count = 0;
    int num_checks = 0;

    always #5 clk_in = ~clk_in;

    fcl_host_model i_fcl_host_model (
        .clk_in(clk_in), .mode_in(mode), .power_in(pwr_req),
        .link_setup_out(setup), .link_connected_out(conn), .board_power_out(pwr)
    );

    fcl_lamps #(.LINK_HALF(LH), .CFG_HALF(CH), .PRM_HALF(PH), .ASIC_HALF(AH)) i_fcl_lamps (
        .clk_in(clk_in), .rst_in(rst_in), .link_setup_in(setup),
        .link_connected_in(conn), .card_online_in(online), .card_offline_in(offline),
        .cfg_err_in(cfg), .prm_err_in(prm), .asic_err_in(asic), .diag_enable_in(diag),
        .board_power_in(pwr), .tx_active_in(tx), .link_status_lamp_out(link_l),
        .online_lamp_out(onl_l), .offline_fault_lamp_out(flt_l),
        .power_lamp_out(pwr_l), .rts_out(rts)
    );

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    function automatic logic lamp(input int i);
        return (i == 0) ? link_l : flt_l;
    endfunction

    task automatic hold(input int i, input logic v, input int n);
        repeat (n)
        begin
            step(1);
            `CHK(lamp(i), v)
        end
    endtask

    // entry half may run long, so only whole halves after a fall are timed
    task automatic blink(input int i, input int half);
        int k;
        k = 0;
        while (lamp(i) !== 1'h1 && k < 200)
        begin
            step(1);
            k++;
        end
        while (lamp(i) !== 1'h0 && k < 200)
        begin
            step(1);
            k++;
        end
        k = 0;
        while (lamp(i) === 1'h0 && k < 200)
        begin
            step(1);
            k++;
        end
        `CHK(k, half)
        k = 0;
        while (lamp(i) === 1'h1 && k < 200)
        begin
            step(1);
            k++;
        end
        `CHK(k, half)
    endtask

    initial
    begin
        rst_in = 1'h1;
        mode = LINK_DOWN;
        pwr_req = 1'h1;
        online = 1'h1;
        offline = 1'h0;
        cfg = 1'h0;
        prm = 1'h0;
        asic = 1'h0;
        diag = 1'h0;
        tx = 1'h1;
        step(12);
        `CHK({link_l, onl_l, flt_l, pwr_l, rts}, 5'h0)
        rst_in = 1'h0;
        step(3);
        `CHK({onl_l, pwr_l, rts}, 3'h7)
        online = 1'h0;
        tx = 1'h0;
        step(1);
        `CHK({onl_l, rts}, 2'h0)
        tx = 1'h1;
        online = 1'h1;
        step(1);
        `CHK({onl_l, rts}, 2'h3)
        pwr_req = 1'h0;
        step(3);
        `CHK(pwr_l, 1'h0)
        $display("test plain lamps done");
        mode = LINK_SETUP;
        step(4);
        hold(0, 1'h1, 20);
        mode = LINK_UP;
        blink(0, LH);
        mode = LINK_DOWN;
        step(4);
        hold(0, 1'h0, 20);
        $display("test link lamp done");
        diag = 1'h1;
        offline = 1'h1;
        step(3);
        hold(1, 1'h1, 20);
        cfg = 1'h1;
        blink(1, CH);
        prm = 1'h1;
        blink(1, PH);
        asic = 1'h1;
        blink(1, AH);
        diag = 1'h0;
        step(3);
        hold(1, 1'h0, 20);
        $display("test fault lamp done");
        print_verdict();
    end

    // whole run is near 200 cycles; this allows 250 times that
    initial
    begin
        #500000;
        err_count++;
        print_verdict();
    end
endmodule

`default_nettype wire
